//--- sci_irq_regs.sv
// APB register block for serial controller one interrupt enable/pending
`timescale 1ns/1ps
module sci_irq_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sci_pkg::ADDR_W-1:0] paddr,
	input wire logic [sci_pkg::DATA_W-1:0] pwdata,
	output logic [sci_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [sci_pkg::SRC_N-1:0] src_evt,
	output logic irq_out
);

	// ----------------------------------------
	// Storage and bus phase decode
	// ----------------------------------------
	logic [sci_pkg::SRC_N-1:0] en_ff; // Enable register
	logic [sci_pkg::SRC_N-1:0] nxt_en; // Next enable value
	logic [sci_pkg::DATA_W-1:0] prdata_ff; // Registered read data
	logic [sci_pkg::DATA_W-1:0] nxt_prdata; // Read data mux
	logic pready_ff; // Access phase ready
	logic pslverr_ff; // Unmapped address error
	logic irq_ff; // Interrupt request
	logic nxt_irq; // Next interrupt request

	sci_flag_if flg (); // Link to flag bank

	wire setup_ph = psel & ~penable; // Setup cycle
	wire done_ph = psel & penable & pready_ff; // Completing access
	wire hit_pend = (paddr == sci_pkg::PEND_ADDR); // Pending selected
	wire hit_enab = (paddr == sci_pkg::ENAB_ADDR); // Enable selected
	wire hit_any = hit_pend | hit_enab; // Mapped address
	wire wr_enab = done_ph & pwrite & hit_enab; // Enable write
	wire wr_pend = done_ph & pwrite & hit_pend; // Pending clear write

	// Enable write; each bit gates only its own source
	// Tx idle and FIFO enables share the same write
	assign nxt_en = wr_enab ? pwdata[sci_pkg::SRC_N-1:0] : en_ff;

	// Read mux, bit 15 and above read zero
	assign nxt_prdata = (setup_ph & ~pwrite & hit_pend) ?
		{{(sci_pkg::DATA_W-sci_pkg::SRC_N){1'b0}}, flg.pend} :
		(setup_ph & ~pwrite & hit_enab) ?
		{{(sci_pkg::DATA_W-sci_pkg::SRC_N){1'b0}}, en_ff} :
		sci_pkg::RD_ZERO;

	// Request while any enabled flag is pending
	assign nxt_irq = |(flg.pend & en_ff);

	// Events map one to one onto pending bits
	// Tx idle lands at its enable position
	assign flg.evt = src_evt;
	assign flg.clr = wr_pend ? pwdata[sci_pkg::SRC_N-1:0] :
		sci_pkg::NO_BITS;

	// ----------------------------------------
	// Pending flags
	// ----------------------------------------
	sci_flag_bank u_bank
	(
		.pclk(pclk),
		.presetn(presetn),
		.flg(flg)
	);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Enable and interrupt request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_ff <= sci_pkg::ENAB_RST;
			irq_ff <= 1'b0;
		end
		else
		begin
			en_ff <= nxt_en;
			irq_ff <= nxt_irq;
		end
	end

	// Bus answer, one cycle after setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= sci_pkg::RD_ZERO;
		end
		else
		begin
			pready_ff <= setup_ph;
			pslverr_ff <= setup_ph & ~hit_any;
			prdata_ff <= nxt_prdata;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq_out = irq_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_irq_follows: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 (irq_out == |($past(flg.pend) & $past(en_ff))))
		else $error("Interrupt does not follow pending and enable");

	a_top_bit_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		(prdata[sci_pkg::DATA_W-1:sci_pkg::SRC_N] == '0))
		else $error("Reserved read bits not zero");

	a_enable_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_enab |=> (en_ff == $past(pwdata[sci_pkg::SRC_N-1:0])))
		else $error("Enable register did not take write");

	a_parity_pos: assert property (
		@(posedge pclk) disable iff (!presetn)
		src_evt[sci_pkg::PARITY_ERROR_IRQ] |=>
			flg.pend[sci_pkg::PARITY_ERROR_IRQ]
			##1 irq_out == en_ff[sci_pkg::PARITY_ERROR_IRQ] ||
			irq_out)
		else $error("Parity error not pending at bit 14");

	a_framing_pos: assert property (
		@(posedge pclk) disable iff (!presetn)
		src_evt[sci_pkg::FRAMING_ERROR_IRQ] |=>
			flg.pend[sci_pkg::FRAMING_ERROR_IRQ])
		else $error("Framing error not pending at bit 13");

	// Each rx buffer is checked on its own event
	a_rx_buf_pos: assert property (
		@(posedge pclk) disable iff (!presetn)
		src_evt[sci_pkg::RX_BUF_A_UNLOADED_IRQ] |=>
			flg.pend[sci_pkg::RX_BUF_A_UNLOADED_IRQ])
		else $error("Rx buffer A unload not pending");

	a_rx_buf_b: assert property (
		@(posedge pclk) disable iff (!presetn)
		src_evt[sci_pkg::RX_BUF_B_UNLOADED_IRQ] |=>
			flg.pend[sci_pkg::RX_BUF_B_UNLOADED_IRQ])
		else $error("Rx buffer B unload not pending");

	a_tx_buf_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		src_evt[sci_pkg::TX_BUF_A_UNLOADED_IRQ] |=>
			flg.pend[sci_pkg::TX_BUF_A_UNLOADED_IRQ])
		else $error("Tx buffer A unload not pending");

	// Enable bits change only through a bus write
	a_enable_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		!wr_enab |=> $stable(en_ff))
		else $error("Enable register changed without a write");

	// Pending read returns the flags seen at setup
	a_pend_read: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_ph & ~pwrite & hit_pend) |=>
			(prdata[sci_pkg::SRC_N-1:0] == $past(flg.pend)))
		else $error("Pending read data wrong");

	// Answer always follows a setup cycle by one edge
	a_ready_setup: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup_ph |=> pready)
		else $error("No ready after setup");

	// Unmapped addresses are refused with an error
	a_err_unmapped: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_ph & ~hit_any) |=> pslverr)
		else $error("Unmapped access gave no error");

	// Read data is zero outside the answer cycle
	a_rdata_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!pready |-> (prdata == sci_pkg::RD_ZERO))
		else $error("Read data not zero while idle");

	a_tx_buf_pos: assert property (
		@(posedge pclk) disable iff (!presetn)
		src_evt[sci_pkg::TX_BUF_B_UNLOADED_IRQ] |=>
			flg.pend[sci_pkg::TX_BUF_B_UNLOADED_IRQ])
		else $error("Tx buffer B unload not pending");

	a_tx_idle_pos: assert property (
		@(posedge pclk) disable iff (!presetn)
		(src_evt[sci_pkg::TX_IDLE_IRQ] & en_ff[sci_pkg::TX_IDLE_IRQ])
			|=> ##1 irq_out)
		else $error("Enabled tx idle raised no interrupt");

	a_ready_once: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("Ready held for two cycles");

endmodule // sci_irq_regs

//--- sci_pkg.sv
// Constants shared by the serial controller one interrupt register block
package sci_pkg;

	// ----------------------------------------
	// Register map and widths
	// ----------------------------------------
	localparam int unsigned ADDR_W = 16; // Byte address width
	localparam int unsigned DATA_W = 32; // Bus data width
	localparam int unsigned SRC_N = 15; // Interrupt sources, bits 14..0
	localparam logic [15:0] PEND_ADDR = 16'h460C; // Pending register
	localparam logic [15:0] ENAB_ADDR = 16'h4624; // Enable register
	localparam logic [14:0] ENAB_RST = 15'h0000; // Enable reset value
	localparam logic [14:0] PEND_RST = 15'h0000; // Pending reset value
	localparam logic [14:0] NO_BITS = 15'h0000; // Nothing cleared
	localparam logic [31:0] RD_ZERO = 32'h00000000; // Idle read data

	// ----------------------------------------
	// Source bit positions, same in both registers
	// ----------------------------------------
	localparam int unsigned RX_HAS_DATA_IRQ = 0;
	localparam int unsigned TX_SPACE_IRQ = 1;
	localparam int unsigned TX_IDLE_IRQ = 2;
	localparam int unsigned RX_OVERRUN_IRQ = 3;
	localparam int unsigned TX_UNDERRUN_IRQ = 4;
	localparam int unsigned RECEIVE_DONE_IRQ = 5;
	localparam int unsigned TRANSMIT_DONE_IRQ = 6;
	localparam int unsigned COMMAND_DONE_IRQ = 7;
	localparam int unsigned NACK_RECEIVED_IRQ = 8;
	localparam int unsigned RX_BUF_A_UNLOADED_IRQ = 9;
	localparam int unsigned RX_BUF_B_UNLOADED_IRQ = 10;
	localparam int unsigned TX_BUF_A_UNLOADED_IRQ = 11;
	localparam int unsigned TX_BUF_B_UNLOADED_IRQ = 12;
	localparam int unsigned FRAMING_ERROR_IRQ = 13;
	localparam int unsigned PARITY_ERROR_IRQ = 14;

endpackage

//--- sci_flag_if.sv
// Interface carrying events, clears and pending flags between modules
`timescale 1ns/1ps
interface sci_flag_if;
	logic [sci_pkg::SRC_N-1:0] evt; // Source event pulses
	logic [sci_pkg::SRC_N-1:0] clr; // Write-one-to-clear mask
	logic [sci_pkg::SRC_N-1:0] pend; // Sticky pending flags

	modport regs (output evt, output clr, input pend);
	modport bank (input evt, input clr, output pend);
endinterface

//--- sci_flag_bank.sv
// Sticky pending flag bank, one flop per interrupt source
`timescale 1ns/1ps
module sci_flag_bank
(
	input wire logic pclk,
	input wire logic presetn,
	sci_flag_if.bank flg
);

	// ----------------------------------------
	// Per-source sticky flags
	// ----------------------------------------
	logic [sci_pkg::SRC_N-1:0] pend_ff; // Pending state
	logic [sci_pkg::SRC_N-1:0] nxt_pend; // Next pending state

	genvar gi;
	generate
		for (gi = 0; gi < sci_pkg::SRC_N; gi++)
		begin : g_flag
			// Event sets regardless of enable; set beats clear
			assign nxt_pend[gi] = flg.evt[gi] |
				(pend_ff[gi] & ~flg.clr[gi]);
		end
	endgenerate

	// Flag register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_ff <= sci_pkg::PEND_RST;
		else
			pend_ff <= nxt_pend;
	end

	assign flg.pend = pend_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_set_beats_clr: assert property (
		@(posedge pclk) disable iff (!presetn)
		(flg.evt != sci_pkg::NO_BITS) |=>
			((flg.pend & $past(flg.evt)) == $past(flg.evt)))
		else $error("Event lost while its flag was cleared");

	a_flag_sticky: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 (($past(flg.pend) & ~$past(flg.clr) & ~flg.pend)
			== sci_pkg::NO_BITS))
		else $error("Pending flag dropped without a clear");

	a_clear_works: assert property (
		@(posedge pclk) disable iff (!presetn)
		(flg.clr != sci_pkg::NO_BITS && flg.evt == sci_pkg::NO_BITS)
			|=> ((flg.pend & $past(flg.clr)) == sci_pkg::NO_BITS))
		else $error("Cleared flag stayed set");

endmodule // sci_flag_bank

//--- sci_irq_regs_tb_top.sv
// Testbench for the serial controller one interrupt register block
`timescale 1ns/1ps
module sci_irq_regs_tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic pclk; // Bus clock
	logic presetn; // Active-low reset
	logic psel;
	logic penable;
	logic pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [14:0] src_evt; // Event pulses
	logic irq_out;
	logic [31:0] rd; // Last read data
	logic [31:0] er; // Last error flag
	logic [31:0] m; // Current source mask
	int fail_count;
	int n_checks;

	sci_irq_regs u_sci_irq_regs
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.src_evt(src_evt),
		.irq_out(irq_out)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Compare, count, report
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; holds until pready seen at an edge
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// Ready, data and error are taken at the edge that sees ready
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		chk("pready_wait", 32'h0, (n == 50) ? 32'h1 : 32'h0);
		rd = prdata;
		er = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle event on source i
	task automatic pulse(input int i);
		@(posedge pclk);
		src_evt <= 15'h0001 << i;
		@(posedge pclk);
		src_evt <= 15'h0000;
	endtask

	// Verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Cuts a hang short well past the expected run
	initial
	begin
		#(40 * 5000);
		fail_count++;
		results();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		fail_count = 0;
		n_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
		src_evt = 15'h0000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, unused top bits 31..15
		apb(1'b0, sci_pkg::PEND_ADDR, 32'h0);
		chk("pend_rst", 32'h0, rd);
		apb(1'b0, sci_pkg::ENAB_ADDR, 32'h0);
		chk("enab_rst", 32'h0, rd);
		chk("irq_rst", 32'h0, {31'h0, irq_out});
		apb(1'b1, sci_pkg::ENAB_ADDR, 32'hFFFFFFFF);
		apb(1'b0, sci_pkg::ENAB_ADDR, 32'h0);
		chk("enab_all", 32'h00007FFF, rd);
		$display("test reset_and_enable done");
		// Every source: set masked, enable, hold, clear
		for (int i = 0; i < 15; i++)
		begin
			m = 32'h1 << i;
			apb(1'b1, sci_pkg::ENAB_ADDR, ~m);
			pulse(i);
			repeat (2) @(posedge pclk);
			#1;
			chk("irq_masked", 32'h0, {31'h0, irq_out});
			apb(1'b0, sci_pkg::PEND_ADDR, 32'h0);
			chk("pend_set", m, rd);
			apb(1'b1, sci_pkg::ENAB_ADDR, m);
			@(posedge pclk);
			#1;
			chk("irq_on", 32'h1, {31'h0, irq_out});
			apb(1'b1, sci_pkg::PEND_ADDR, ~m);
			apb(1'b0, sci_pkg::PEND_ADDR, 32'h0);
			chk("pend_hold", m, rd);
			apb(1'b1, sci_pkg::PEND_ADDR, m);
			@(posedge pclk);
			#1;
			chk("irq_off", 32'h0, {31'h0, irq_out});
		end
		$display("test per_source done");
		// Enabled tx idle event raises the request two edges on
		apb(1'b1, sci_pkg::ENAB_ADDR, 32'h00000004);
		pulse(2);
		repeat (2) @(posedge pclk);
		#1;
		chk("irq_idle", 32'h1, {31'h0, irq_out});
		apb(1'b1, sci_pkg::PEND_ADDR, 32'h00000004);
		@(posedge pclk);
		#1;
		chk("irq_idle_off", 32'h0, {31'h0, irq_out});
		apb(1'b1, sci_pkg::ENAB_ADDR, 32'h00004000);
		$display("test tx_idle done");
		// Unmapped address refused, registers untouched
		apb(1'b1, 16'h4610, 32'h00000001);
		chk("err_wr", 32'h1, er);
		apb(1'b0, 16'h4610, 32'h0);
		chk("err_rd", 32'h1, er);
		chk("rd_unmapped", 32'h0, rd);
		apb(1'b0, sci_pkg::ENAB_ADDR, 32'h0);
		chk("enab_kept", 32'h00004000, rd);
		$display("test unmapped done");
		results();
	end
endmodule // sci_irq_regs_tb_top
